// ===== design/lmc_config_bank.sv
// Configuration register bank of the 24-sink, four-line LED matrix driver
// Behaviour
// [RL1] Four scale pages, one per scan line, each hold one byte per sink at even offsets 0x02-0x30.
// [RL2] A sink's current follows its scale byte over 256, 0x00 is off, and each byte resets to 0xff.
// [RL3] The run-enable bit D1 of the configuration register shuts the device down at 0 and resets to 1.
// [RL4] The scan-select field D6:D4 sets the scan duty, and its reset code 000 scans all four lines.
// [RL5] Codes 001, 010, 011 scan three, two or one line, and 100 scans two with lines 2/3 copying 0/1.
// [RL6] The PWM-rate field D3:D2 picks 25.6 kHz, 51.2 kHz, 800 Hz or 400 Hz, reset 00.
// [RL7] Each colour gain holds seven bits in D7:D1 with D0 unused and resets to all ones.
// [RL8] Gain 0x04 serves red sinks, 0x06 green and 0x08 blue, chosen by sink index modulo three.
// [RL9] Peak sink current is proportional to gain over 256 times scale byte over 256.
// [RL10] Spread-enable D1 dithers the clock by plus or minus five percent and resets to off.
// [RL11] The spread-period field D5:D4 sets the dither cycle to 1980, 1200, 820 or 660 us.
// [RL12] Sync mode D3:D2 at 0x disables the pin with pull-down, 10 follows a clock, 11 leads one.
// [RL13] Reserved bit positions ignore writes and stay zero.
`timescale 1ns/10ps
`default_nettype none
module lmc_config_bank #(
    parameter int PWM_CYC_0 = lmc_pkg::CLK_HZ / lmc_pkg::PWM_HZ_0,
    parameter int PWM_CYC_1 = lmc_pkg::CLK_HZ / lmc_pkg::PWM_HZ_1,
    parameter int PWM_CYC_2 = lmc_pkg::CLK_HZ / lmc_pkg::PWM_HZ_2,
    parameter int PWM_CYC_3 = lmc_pkg::CLK_HZ / lmc_pkg::PWM_HZ_3,
    parameter int SPR_STEP_0 = lmc_pkg::SPR_US_0 * lmc_pkg::CLK_MHZ / lmc_pkg::SPR_STEPS,
    parameter int SPR_STEP_1 = lmc_pkg::SPR_US_1 * lmc_pkg::CLK_MHZ / lmc_pkg::SPR_STEPS,
    parameter int SPR_STEP_2 = lmc_pkg::SPR_US_2 * lmc_pkg::CLK_MHZ / lmc_pkg::SPR_STEPS,
    parameter int SPR_STEP_3 = lmc_pkg::SPR_US_3 * lmc_pkg::CLK_MHZ / lmc_pkg::SPR_STEPS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    regWrEn,
    input  wire logic [7:0]              regPage,
    input  wire logic [7:0]              regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    syncIn,
    output logic                         syncOut,
    output logic                         syncOe,
    output logic                         syncPullDown,
    output logic [3:0]                   scanSwitchOn,
    output logic [1:0]                   activeLine,
    output logic                         scanFrameStart,
    output logic [23:0][15:0]            sinkCurrent,
    output logic                         runEnable,
    output logic [1:0]                   pwmRateSel,
    output logic [19:0]                  pwmPeriodCycles,
    output logic signed [3:0]            clockTrimPct
);
    logic [7:0]              scaleMem [lmc_pkg::NUM_LINES][lmc_pkg::NUM_SINKS];
    logic [7:0]              cfgByte_q;
    logic [7:0]              gainR_q;
    logic [7:0]              gainG_q;
    logic [7:0]              gainB_q;
    logic [7:0]              sprByte_q;
    lmc_pkg::lmc_cfg_t       cfg;
    lmc_pkg::lmc_spread_t    spr;
    logic                    funcWr;
    logic [19:0]             pwmPeriod_q;
    logic [23:0][15:0]       sinkCurrent_q;
    logic [19:0]             sprCnt_q;
    logic [19:0]             sprStep;
    logic signed [3:0]       trim_q;
    lmc_pkg::lmc_spr_state_t sprState_q;
    logic                    syncMeta_q;
    logic                    syncSync_q;
    logic                    syncPrev_q;
    logic                    followEdge;
    logic                    syncOut_q;
    logic                    syncOe_q;
    logic                    syncPd_q;
    logic [1:0]              seqLine;
    logic [3:0]              seqSw;
    logic                    seqFrame;

    function automatic logic isScaleAddr(input logic [7:0] page, input logic [7:0] addr);
        isScaleAddr = (page >= lmc_pkg::PAGE_SCALE0) && (page <= lmc_pkg::PAGE_SCALE3)
                   && !page[0] && !addr[0]
                   && (addr >= lmc_pkg::OFS_SCALE_FIRST) && (addr <= lmc_pkg::OFS_SCALE_LAST);
    endfunction

    function automatic logic [7:0] halfIndex(input logic [7:0] a, input logic [7:0] base);
        halfIndex = (a - base) >> 1;
    endfunction

    function automatic logic [7:0] groupGain(input int sink, input logic [7:0] r,
                                             input logic [7:0] g, input logic [7:0] b);
        case (sink % lmc_pkg::NUM_GROUPS)
            0:       groupGain = r;
            1:       groupGain = g;
            default: groupGain = b;
        endcase
    endfunction

    assign funcWr = regWrEn && (regPage == lmc_pkg::PAGE_FUNC);
    assign cfg = '{scanSel: cfgByte_q[lmc_pkg::CFG_SCAN_LSB +: 3],
                   pwmRate: cfgByte_q[lmc_pkg::CFG_RATE_LSB +: 2],
                   runEn:   cfgByte_q[lmc_pkg::CFG_RUN_BIT]};
    assign spr = '{period:   sprByte_q[lmc_pkg::SPR_PER_LSB +: 2],
                   syncMode: sprByte_q[lmc_pkg::SPR_SYNC_LSB +: 2],
                   en:       sprByte_q[lmc_pkg::SPR_EN_BIT]};

    // Scale pages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int l = 0; l < lmc_pkg::NUM_LINES; l++) begin
                for (int s = 0; s < lmc_pkg::NUM_SINKS; s++) begin
                    scaleMem[l][s] <= lmc_pkg::SCALE_RST; // [RL2]
                end
            end
        end else if (regWrEn && isScaleAddr(regPage, regAddr)) begin
            scaleMem[2'(halfIndex(regPage, lmc_pkg::PAGE_SCALE0))][5'(halfIndex(regAddr,
                lmc_pkg::OFS_SCALE_FIRST))] <= regWrData; // [RL1]
        end
    end

    // Function page; masks keep reserved bits at zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfgByte_q <= lmc_pkg::CFG_RST; // [RL3] [RL4] [RL6]
            gainR_q   <= lmc_pkg::GAIN_RST; // [RL7]
            gainG_q   <= lmc_pkg::GAIN_RST;
            gainB_q   <= lmc_pkg::GAIN_RST;
            sprByte_q <= lmc_pkg::SPR_RST; // [RL10]
        end else if (funcWr) begin
            case (regAddr)
                lmc_pkg::OFS_CFG:    cfgByte_q <= regWrData & lmc_pkg::CFG_MASK; // [RL13]
                lmc_pkg::OFS_GAIN_R: gainR_q   <= regWrData & lmc_pkg::GAIN_MASK; // [RL7] [RL8]
                lmc_pkg::OFS_GAIN_G: gainG_q   <= regWrData & lmc_pkg::GAIN_MASK; // [RL8]
                lmc_pkg::OFS_GAIN_B: gainB_q   <= regWrData & lmc_pkg::GAIN_MASK; // [RL8]
                lmc_pkg::OFS_SPREAD: sprByte_q <= regWrData & lmc_pkg::SPR_MASK; // [RL13]
                default: ;
            endcase
        end
    end

    // PWM period from rate code
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwmPeriod_q <= 20'(PWM_CYC_0);
        end else begin
            case (cfg.pwmRate)
                2'h1:    pwmPeriod_q <= 20'(PWM_CYC_1); // [RL6]
                2'h2:    pwmPeriod_q <= 20'(PWM_CYC_2);
                2'h3:    pwmPeriod_q <= 20'(PWM_CYC_3);
                default: pwmPeriod_q <= 20'(PWM_CYC_0);
            endcase
        end
    end

    lmc_scan_seq u_seq (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .runEn        (cfg.runEn),
        .restart      (followEdge),
        .scanSel      (cfg.scanSel),
        .periodCycles (pwmPeriod_q),
        .line         (seqLine),
        .swOn         (seqSw),
        .frameStart   (seqFrame)
    );

    // Sink current: gain/256 times scale/256 for the active line
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sinkCurrent_q <= '0;
        end else begin
            for (int s = 0; s < lmc_pkg::NUM_SINKS; s++) begin
                sinkCurrent_q[s] <= cfg.runEn
                    ? 16'(groupGain(s, gainR_q, gainG_q, gainB_q)) * 16'(scaleMem[seqLine][s])
                    : 16'h0; // [RL2] [RL3] [RL8] [RL9]
            end
        end
    end

    // Spread-spectrum triangle dither
    always_comb begin
        case (spr.period)
            2'h1:    sprStep = 20'(SPR_STEP_1); // [RL11]
            2'h2:    sprStep = 20'(SPR_STEP_2);
            2'h3:    sprStep = 20'(SPR_STEP_3);
            default: sprStep = 20'(SPR_STEP_0);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !spr.en) begin
            sprCnt_q   <= '0;
            trim_q     <= '0; // [RL10]
            sprState_q <= lmc_pkg::SPR_UP;
        end else if (sprCnt_q >= sprStep - 20'h1) begin
            sprCnt_q <= '0;
            case (sprState_q)
                lmc_pkg::SPR_UP: begin
                    if (trim_q >= lmc_pkg::TRIM_MAX) begin
                        sprState_q <= lmc_pkg::SPR_DOWN;
                        trim_q     <= trim_q - lmc_pkg::TRIM_ONE;
                    end else begin
                        trim_q <= trim_q + lmc_pkg::TRIM_ONE; // [RL10]
                    end
                end
                lmc_pkg::SPR_DOWN: begin
                    if (trim_q <= lmc_pkg::TRIM_MIN) begin
                        sprState_q <= lmc_pkg::SPR_UP;
                        trim_q     <= trim_q + lmc_pkg::TRIM_ONE;
                    end else begin
                        trim_q <= trim_q - lmc_pkg::TRIM_ONE;
                    end
                end
                default: sprState_q <= lmc_pkg::SPR_UP;
            endcase
        end else begin
            sprCnt_q <= sprCnt_q + 20'h1;
        end
    end

    // Sync pin: follower restarts the frame on the input's rising edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            syncMeta_q <= 1'b0;
            syncSync_q <= 1'b0;
            syncPrev_q <= 1'b0;
        end else begin
            syncMeta_q <= syncIn;
            syncSync_q <= syncMeta_q;
            syncPrev_q <= syncSync_q;
        end
    end

    assign followEdge = (spr.syncMode == lmc_pkg::SYNC_FOLLOW) && syncSync_q && !syncPrev_q; // [RL12]

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            syncOut_q <= 1'b0;
            syncOe_q  <= 1'b0;
            syncPd_q  <= 1'b1;
        end else begin
            syncOe_q  <= spr.syncMode == lmc_pkg::SYNC_LEAD; // [RL12]
            syncOut_q <= (spr.syncMode == lmc_pkg::SYNC_LEAD) && seqFrame;
            syncPd_q  <= !spr.syncMode[lmc_pkg::SYNC_ON_BIT];
        end
    end

    assign syncOut         = syncOut_q;
    assign syncOe          = syncOe_q;
    assign syncPullDown    = syncPd_q;
    assign scanSwitchOn    = seqSw;
    assign activeLine      = seqLine;
    assign scanFrameStart  = seqFrame;
    assign sinkCurrent     = sinkCurrent_q;
    assign runEnable       = cfgByte_q[lmc_pkg::CFG_RUN_BIT];
    assign pwmRateSel      = cfgByte_q[lmc_pkg::CFG_RATE_LSB +: 2];
    assign pwmPeriodCycles = pwmPeriod_q;
    assign clockTrimPct    = trim_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    run_write_a: assert property (funcWr && regAddr == lmc_pkg::OFS_CFG |=> // [RL3]
        runEnable == $past(regWrData[lmc_pkg::CFG_RUN_BIT])) else $error("run enable not stored");
    shutdown_dark_a: assert property (!runEnable |=> scanSwitchOn == 4'h0 // [RL3]
        && sinkCurrent == '0) else $error("shutdown left outputs active");
    scan_all_a: assert property (runEnable && cfg.scanSel == lmc_pkg::SCAN_ALL |=> // [RL4]
        $onehot(scanSwitchOn)) else $error("full scan not one-hot");
    scan_one_a: assert property (runEnable && cfg.scanSel == lmc_pkg::SCAN_ONE |=> // [RL5]
        scanSwitchOn == 4'h1) else $error("single-line scan wrong");
    scan_mirror_a: assert property (cfg.scanSel == lmc_pkg::SCAN_MIRROR |=> // [RL5]
        scanSwitchOn[2] == scanSwitchOn[0] && scanSwitchOn[3] == scanSwitchOn[1])
        else $error("mirror scan mismatch");
    pwm_rate_a: assert property (pwmRateSel == 2'h2 |=> // [RL6]
        pwmPeriodCycles == 20'(PWM_CYC_2)) else $error("pwm period wrong");
    green_product_a: assert property (runEnable |=> sinkCurrent[4] == // [RL8] [RL9]
        16'($past(gainG_q)) * 16'($past(scaleMem[seqLine][4])))
        else $error("green sink product wrong");
    reserved_zero_a: assert property (!gainR_q[0] && !gainB_q[0] // [RL13] [RL7]
        && (cfgByte_q & ~lmc_pkg::CFG_MASK) == 8'h0) else $error("reserved bit set");
    trim_range_a: assert property (clockTrimPct <= lmc_pkg::TRIM_MAX // [RL10]
        && clockTrimPct >= lmc_pkg::TRIM_MIN) else $error("trim out of range");
    trim_off_a: assert property (!spr.en |=> clockTrimPct == 4'sh0) // [RL10]
        else $error("trim not cleared");
    sync_mode_a: assert property (!spr.syncMode[lmc_pkg::SYNC_ON_BIT] |=> // [RL12]
        syncPullDown && !syncOe) else $error("disabled sync pin driven");
endmodule
`default_nettype wire

// ===== design/lmc_pkg.sv
// Shared constants, types and decode helpers for the LED matrix current configuration bank
package lmc_pkg;
    localparam int NUM_SINKS  = 24;
    localparam int NUM_LINES  = 4;
    localparam int NUM_GROUPS = 3;

    // Page selectors and register offsets
    localparam logic [7:0] PAGE_SCALE0    = 8'h66;
    localparam logic [7:0] PAGE_SCALE3    = 8'h6c;
    localparam logic [7:0] PAGE_FUNC      = 8'h6e;
    localparam logic [7:0] OFS_SCALE_FIRST = 8'h02;
    localparam logic [7:0] OFS_SCALE_LAST = 8'h30;
    localparam logic [7:0] OFS_CFG        = 8'h02;
    localparam logic [7:0] OFS_GAIN_R     = 8'h04;
    localparam logic [7:0] OFS_GAIN_G     = 8'h06;
    localparam logic [7:0] OFS_GAIN_B     = 8'h08;
    localparam logic [7:0] OFS_SPREAD     = 8'h0a;

    // Field positions
    localparam int CFG_RUN_BIT  = 1;
    localparam int CFG_RATE_LSB = 2;
    localparam int CFG_SCAN_LSB = 4;
    localparam int SPR_EN_BIT   = 1;
    localparam int SPR_SYNC_LSB = 2;
    localparam int SPR_PER_LSB  = 4;

    // Implemented bits; everything else is stored as zero
    localparam logic [7:0] CFG_MASK  = 8'h7e;
    localparam logic [7:0] GAIN_MASK = 8'hfe;
    localparam logic [7:0] SPR_MASK  = 8'h3e;

    // Reset values
    localparam logic [7:0] SCALE_RST = 8'hff;
    localparam logic [7:0] CFG_RST   = 8'h02;
    localparam logic [7:0] GAIN_RST  = 8'hfe;
    localparam logic [7:0] SPR_RST   = 8'h00;

    // Timing
    localparam int CLK_MHZ      = 250;
    localparam int CLK_HZ       = 250_000_000;
    localparam int PWM_HZ_0     = 25_600;
    localparam int PWM_HZ_1     = 51_200;
    localparam int PWM_HZ_2     = 800;
    localparam int PWM_HZ_3     = 400;
    localparam int SPR_US_0     = 1980;
    localparam int SPR_US_1     = 1200;
    localparam int SPR_US_2     = 820;
    localparam int SPR_US_3     = 660;
    localparam int SPR_PCT      = 5;
    localparam int SPR_STEPS    = 4 * SPR_PCT;
    localparam logic signed [3:0] TRIM_MAX = 4'sh5;
    localparam logic signed [3:0] TRIM_MIN = -4'sh5;
    localparam logic signed [3:0] TRIM_ONE = 4'sh1;

    // Sync pin modes
    localparam logic [1:0] SYNC_FOLLOW = 2'h2;
    localparam logic [1:0] SYNC_LEAD   = 2'h3;
    localparam int         SYNC_ON_BIT = 1;

    typedef enum logic [2:0] {
        SCAN_ALL    = 3'h0,
        SCAN_THREE  = 3'h1,
        SCAN_TWO    = 3'h2,
        SCAN_ONE    = 3'h3,
        SCAN_MIRROR = 3'h4
    } lmc_scan_e_t;

    typedef enum logic [1:0] {
        SPR_UP   = 2'b01,
        SPR_DOWN = 2'b10
    } lmc_spr_state_t;

    typedef struct packed {
        logic [2:0] scanSel;
        logic [1:0] pwmRate;
        logic       runEn;
    } lmc_cfg_t;

    typedef struct packed {
        logic [1:0] period;
        logic [1:0] syncMode;
        logic       en;
    } lmc_spread_t;

    // Highest scan line used by a scan-select code
    function automatic logic [1:0] lastLine(input logic [2:0] sel);
        case (sel)
            SCAN_THREE:  lastLine = 2'h2;
            SCAN_TWO:    lastLine = 2'h1;
            SCAN_ONE:    lastLine = 2'h0;
            SCAN_MIRROR: lastLine = 2'h1;
            default:     lastLine = 2'h3;
        endcase
    endfunction

    // Switch pattern for an active line; mirror mode copies 0/1 onto 2/3
    function automatic logic [3:0] switchMap(input logic [1:0] line, input logic [2:0] sel);
        logic [3:0] m;
        m = 4'h1 << line;
        if (sel == SCAN_MIRROR) begin
            m = m | (m << 2);
        end
        switchMap = m;
    endfunction
endpackage

// ===== design/lmc_scan_seq.sv
// Scan-line sequencer: steps the active line once per PWM period
`timescale 1ns/10ps
`default_nettype none
module lmc_scan_seq (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        runEn,
    input  wire logic        restart,
    input  wire logic [2:0]  scanSel,
    input  wire logic [19:0] periodCycles,
    output logic      [1:0]  line,
    output logic      [3:0]  swOn,
    output logic             frameStart
);
    logic [19:0] cnt_q;
    logic [1:0]  line_q;
    logic [1:0]  line_d;
    logic [3:0]  swOn_q;
    logic        frameStart_q;
    logic        wrap;
    logic [1:0]  last;

    always_comb begin
        last   = lmc_pkg::lastLine(scanSel);
        wrap   = cnt_q >= (periodCycles - 20'h1);
        line_d = line_q;
        if (restart) begin
            line_d = '0;
        end else if (wrap) begin
            line_d = (line_q >= last) ? 2'h0 : line_q + 2'h1;
        end else if (line_q > last) begin
            line_d = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !runEn || restart || wrap) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 20'h1;
        end
    end

    // Lines beyond the selected count never become active
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            line_q       <= '0;
            swOn_q       <= '0;
            frameStart_q <= 1'b0;
        end else begin
            line_q       <= runEn ? line_d : 2'h0;
            swOn_q       <= runEn ? lmc_pkg::switchMap(line_d, scanSel) : 4'h0; // [RL4] [RL5]
            frameStart_q <= runEn && (restart || wrap) && (line_d == 2'h0);
        end
    end

    assign line       = line_q;
    assign swOn       = swOn_q;
    assign frameStart = frameStart_q;
endmodule
`default_nettype wire

// ===== tb/lmc_host_model.sv
// Host model issuing register writes on the parallel write port
`timescale 1ns/10ps
`default_nettype none
module lmc_host_model (
    input  wire logic      sys_clk,
    output var logic       regWrEn,
    output var logic [7:0] regPage,
    output var logic [7:0] regAddr,
    output var logic [7:0] regWrData
);
    initial begin
        regWrEn   = 1'b0;
        regPage   = 8'h00;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // One strobe per byte; idle fields inverted so stale values never look valid
    task automatic writeReg(input logic [7:0] page, input logic [7:0] addr,
                            input logic [7:0] data);
        @(posedge sys_clk);
        regWrEn   <= 1'b1;
        regPage   <= page;
        regAddr   <= addr;
        regWrData <= data;
        @(posedge sys_clk);
        regWrEn   <= 1'b0;
        regPage   <= ~page;
        regAddr   <= ~addr;
        regWrData <= ~data;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_lmc_config_bank.sv
// Self-checking bench for the LED matrix current configuration bank
`timescale 1ns/10ps
`default_nettype none
module test_lmc_config_bank;
    localparam int PWM_CYC [4] = '{8, 12, 16, 20};
    localparam int SPR_STEP [4] = '{4, 6, 8, 10};
    logic sys_clk, sys_rst, regWrEn, syncIn, syncOut, syncOe, syncPullDown;
    logic scanFrameStart, runEnable;
    logic [7:0] regPage, regAddr, regWrData;
    logic [3:0] scanSwitchOn;
    logic [1:0] activeLine, pwmRateSel;
    logic [23:0][15:0] sinkCurrent;
    logic [19:0] pwmPeriodCycles;
    logic signed [3:0] clockTrimPct;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    lmc_config_bank #(
        .PWM_CYC_0(PWM_CYC[0]), .PWM_CYC_1(PWM_CYC[1]),
        .PWM_CYC_2(PWM_CYC[2]), .PWM_CYC_3(PWM_CYC[3]),
        .SPR_STEP_0(SPR_STEP[0]), .SPR_STEP_1(SPR_STEP[1]),
        .SPR_STEP_2(SPR_STEP[2]), .SPR_STEP_3(SPR_STEP[3])
    ) lmc_config_bank_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regPage(regPage),
        .regAddr(regAddr), .regWrData(regWrData), .syncIn(syncIn), .syncOut(syncOut),
        .syncOe(syncOe), .syncPullDown(syncPullDown), .scanSwitchOn(scanSwitchOn),
        .activeLine(activeLine), .scanFrameStart(scanFrameStart),
        .sinkCurrent(sinkCurrent), .runEnable(runEnable), .pwmRateSel(pwmRateSel),
        .pwmPeriodCycles(pwmPeriodCycles), .clockTrimPct(clockTrimPct)
    );

    lmc_host_model lmc_host_model_i (
        .sys_clk(sys_clk), .regWrEn(regWrEn), .regPage(regPage),
        .regAddr(regAddr), .regWrData(regWrData)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
        lmc_host_model_i.writeReg(page, addr, data);
    endtask

    task automatic cfg(input logic [7:0] data);
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_CFG, data);
    endtask

    task automatic waitLine(input logic [1:0] n);
        int k;
        k = 0;
        while (activeLine !== n && k < 100) begin
            step(1);
            k++;
        end
        chk("activeLine", 32'(n), 32'(activeLine));
    endtask

    task automatic test_reset();
        chk("runEnable", 32'h1, 32'(runEnable));
        chk("pwmRateSel", 32'h0, 32'(pwmRateSel));
        chk("pwmPeriodCycles", PWM_CYC[0], 32'(pwmPeriodCycles));
        chk("syncPullDown", 32'h1, 32'(syncPullDown));
        chk("syncOe", 32'h0, 32'(syncOe));
        chk("clockTrimPct", 32'h0, {28'h0, clockTrimPct});
        step(4);
        chk("sinkCurrent0", 32'hfd02, 32'(sinkCurrent[0]));
        chk("sinkCurrent23", 32'hfd02, 32'(sinkCurrent[23]));
        $display("test reset done");
    endtask

    task automatic test_rates();
        for (int r = 0; r < 4; r++) begin
            cfg({4'h0, 2'(r), 2'b10});
            step(2);
            chk("pwmRateSel", r, 32'(pwmRateSel));
            chk("pwmPeriodCycles", PWM_CYC[r], 32'(pwmPeriodCycles));
        end
        cfg(8'h8d);
        step(2);
        chk("runEnableMasked", 32'h0, 32'(runEnable));
        $display("test rates done");
    endtask

    task automatic test_scale();
        cfg(8'h32);
        wr(8'h66, 8'h02, 8'h00);
        wr(8'h66, 8'h04, 8'h01);
        wr(8'h66, 8'h03, 8'h00);
        wr(8'h66, 8'h30, 8'h80);
        wr(8'h6c, 8'h02, 8'h10);
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_GAIN_R, 8'h81);
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_GAIN_G, 8'h40);
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_GAIN_B, 8'h03);
        step(40);
        chk("sinkCurrent0", 32'h0, 32'(sinkCurrent[0]));
        chk("sinkCurrent1", 32'h40, 32'(sinkCurrent[1]));
        chk("sinkCurrent3", 32'h7f80, 32'(sinkCurrent[3]));
        chk("sinkCurrent23", 32'h100, 32'(sinkCurrent[23]));
        cfg(8'h02);
        waitLine(2'h3);
        step(2);
        chk("sinkCurrentLine3", 32'h800, 32'(sinkCurrent[0]));
        $display("test scale done");
    endtask

    task automatic test_scan();
        logic [3:0] seen;
        logic [3:0] expSeen [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'hf};
        logic [3:0] expFrames [5] = '{4'h2, 4'h0, 4'h4, 4'h8, 4'h4};
        int frames;
        for (int c = 0; c < 5; c++) begin
            cfg({1'b0, 3'(c), 4'h2});
            step(40);
            seen = 4'h0;
            frames = 0;
            repeat (64) begin
                step(1);
                seen = seen | scanSwitchOn;
                if (scanFrameStart === 1'b1) frames++;
                if (scanFrameStart === 1'b1 && activeLine !== 2'h0) begin
                    chk("frameLine", 32'h0, 32'(activeLine));
                end
                if (c == 4 && scanSwitchOn !== 4'h5 && scanSwitchOn !== 4'ha) begin
                    chk("mirrorPattern", 32'h5, 32'(scanSwitchOn));
                end
            end
            chk("switchesUsed", 32'(expSeen[c]), 32'(seen));
            if (c != 1) chk("frameStarts", 32'(expFrames[c]), 32'(frames));
        end
        $display("test scan done");
    endtask

    task automatic test_shutdown();
        cfg(8'h00);
        step(3);
        chk("runEnable", 32'h0, 32'(runEnable));
        chk("scanSwitchOn", 32'h0, 32'(scanSwitchOn));
        chk("sinkCurrent3", 32'h0, 32'(sinkCurrent[3]));
        cfg(8'h02);
        $display("test shutdown done");
    endtask

    task automatic waitTrim(output int n);
        logic signed [3:0] t;
        n = 0;
        t = clockTrimPct;
        while (clockTrimPct === t && n < 40) begin
            step(1);
            n++;
        end
    endtask

    task automatic test_spread();
        int n;
        logic signed [3:0] hi;
        logic signed [3:0] lo;
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, 8'h02);
        hi = 4'sh0;
        lo = 4'sh0;
        repeat (100) begin
            step(1);
            if (clockTrimPct > hi) hi = clockTrimPct;
            if (clockTrimPct < lo) lo = clockTrimPct;
        end
        chk("trimMax", 32'h5, {28'h0, hi});
        chk("trimMin", 32'hb, {28'h0, lo});
        for (int c = 0; c < 4; c++) begin
            wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, {2'h3, 2'(c), 4'h2});
            waitTrim(n);
            waitTrim(n);
            waitTrim(n);
            chk("trimDwell", SPR_STEP[c], n);
        end
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, 8'h00);
        step(2);
        chk("trimOff", 32'h0, {28'h0, clockTrimPct});
        $display("test spread done");
    endtask

    task automatic test_sync();
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, 8'h04);
        step(2);
        chk("syncPullDown", 32'h1, 32'(syncPullDown));
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, 8'h08);
        step(2);
        chk("syncPullDown", 32'h0, 32'(syncPullDown));
        chk("syncOe", 32'h0, 32'(syncOe));
        waitLine(2'h2);
        @(posedge sys_clk);
        syncIn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        syncIn <= 1'b0;
        step(4);
        chk("followRestart", 32'h0, 32'(activeLine));
        wr(lmc_pkg::PAGE_FUNC, lmc_pkg::OFS_SPREAD, 8'h0c);
        step(2);
        chk("syncOe", 32'h1, 32'(syncOe));
        for (int k = 0; k < 60 && syncOut !== 1'b1; k++) step(1);
        chk("syncOut", 32'h1, 32'(syncOut));
        $display("test sync done");
    endtask

    initial begin
        sys_rst = 1'b1;
        syncIn = 1'b0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        step(1);
        test_reset();
        test_rates();
        test_scale();
        test_scan();
        test_shutdown();
        test_spread();
        test_sync();
        finish_test();
    end
endmodule
`default_nettype wire
